// ---- hdl/gpio_alternate_function_mux.sv ----
// How it works
// - Each of the nine pins runs as plain GPIO, first alternate or second alternate function.
// - Pins 0-3 in first alternate function start a fundamental reset of partitions 0-3.
// - A failover input pulses an event on each level change, only while that failover is enabled.
// - Pin 6 in second alternate function is the fourth failover input, with the same behaviour.
// - In second alternate function pins 0, 2, 4, 7 drive link-up of ports 16, 4, 0, 8.
// - In second alternate function pins 1, 3, 5, 8 drive link-active of ports 16, 4, 0, 8.
// - Pin 5 in first alternate function drives the hot-plug event indication out.
// - Pin 8 in first alternate function takes the interrupt request of the I/O expanders.
// - Four stack strap inputs each select the configuration of stacks 0 to 3.
// - A two-bit clock mode strap chooses the port clocking mode.
// - The frequency select strap sets the reference clock: 0 is 100 MHz, 1 is 125 MHz.
`default_nettype none
module gpio_alternate_function_mux
  import gpio_mux_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst,
  // Function select configuration (two bits per pin)
  input  wire logic                  i_func_sel_we,
  input  wire logic [2*NUM_PINS-1:0] i_func_sel,
  output logic      [2*NUM_PINS-1:0] o_func_sel,
  // Plain GPIO side
  input  wire logic [NUM_PINS-1:0]   i_gpio_out,
  input  wire logic [NUM_PINS-1:0]   i_gpio_dir_out,
  output logic      [NUM_PINS-1:0]   o_gpio_in,
  // Pins (input, output, output enable)
  input  wire logic [NUM_PINS-1:0]   i_pin,
  output logic      [NUM_PINS-1:0]   o_pin,
  output logic      [NUM_PINS-1:0]   o_pin_oe,
  // Partition resets
  output logic      [3:0]            o_partition_reset,
  // Failover
  input  wire logic [3:0]            i_failover_enable,
  output logic      [3:0]            o_failover_event,
  // Hot-plug event and expander interrupt
  input  wire logic                  i_hotplug_event,
  output logic                       o_expander_irq,
  // Link status, index 0..3 = ports 0, 4, 8, 16, active high
  input  wire logic [3:0]            i_link_up,
  input  wire logic [3:0]            i_link_active,
  // Straps
  input  wire logic [3:0]            i_stack_config_strap,
  input  wire logic [1:0]            i_port_clocking_strap,
  input  wire logic                  i_refclk_freq_select,
  output logic      [3:0]            o_stack_config,
  output logic      [1:0]            o_port_clocking_mode,
  output logic                       o_refclk_freq_select,
  output logic      [7:0]            o_refclk_mhz
);
  // Port index of link status vectors
  localparam int unsigned LP0  = 0;
  localparam int unsigned LP4  = 1;
  localparam int unsigned LP8  = 2;
  localparam int unsigned LP16 = 3;
  // Width of the strap settle counter
  localparam int unsigned STRAP_CNT_W = $clog2(STRAP_SETTLE_CYCLES + 1);

  logic [2*NUM_PINS-1:0] func_q, func_d;
  logic [NUM_PINS-1:0]   pin_s;
  logic [NUM_PINS-1:0]   pin_out_d, pin_out_q, pin_oe_d, pin_oe_q;
  logic [NUM_PINS-1:0]   gpio_in_d, gpio_in_q;
  logic [3:0]            preset_d, preset_q;
  logic [3:0]            fo_lvl, fo_sel, fo_prev_q, fo_prev_d, fo_ev_d, fo_ev_q;
  logic                  irq_d, irq_q;
  logic [6:0]            strap_s;
  logic [6:0]            strap_d, strap_q;
  logic                  strap_done_d, strap_done_q;
  logic [STRAP_CNT_W-1:0] strap_cnt_d, strap_cnt_q;
  logic [1:0]            fsel [NUM_PINS];

  // Pin and strap synchronisers
  pin_sync #(.WIDTH(NUM_PINS), .RST_VAL(PIN_SYNC_RST)) u_pin_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_async   (i_pin),
    .o_sync    (pin_s)
  );
  pin_sync #(.WIDTH(7), .RST_VAL(7'h00)) u_strap_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_async   ({i_refclk_freq_select, i_port_clocking_strap, i_stack_config_strap}),
    .o_sync    (strap_s)
  );

  // Per-pin select fields
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_sel
    assign fsel[p] = func_q[2*p +: 2];
  end

  // Function select state, written whole by configuration
  always_comb begin
    func_d = func_q;
    if (i_func_sel_we) begin
      func_d = i_func_sel;
    end
  end

  // Pin drive: plain GPIO, status outputs or hot-plug event; inputs released
  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      pin_out_d[p] = i_gpio_out[p];
      pin_oe_d[p]  = (fsel[p] == FUNC_GPIO) ? i_gpio_dir_out[p] : 1'b0;
    end
    // Second alternate: link status outputs, active low
    if (fsel[0] == FUNC_ALT2) begin
      pin_out_d[0] = ~i_link_up[LP16];
      pin_oe_d[0]  = 1'b1;
    end
    if (fsel[2] == FUNC_ALT2) begin
      pin_out_d[2] = ~i_link_up[LP4];
      pin_oe_d[2]  = 1'b1;
    end
    if (fsel[4] == FUNC_ALT2) begin
      pin_out_d[4] = ~i_link_up[LP0];
      pin_oe_d[4]  = 1'b1;
    end
    if (fsel[7] == FUNC_ALT2) begin
      pin_out_d[7] = ~i_link_up[LP8];
      pin_oe_d[7]  = 1'b1;
    end
    if (fsel[1] == FUNC_ALT2) begin
      pin_out_d[1] = ~i_link_active[LP16];
      pin_oe_d[1]  = 1'b1;
    end
    if (fsel[3] == FUNC_ALT2) begin
      pin_out_d[3] = ~i_link_active[LP4];
      pin_oe_d[3]  = 1'b1;
    end
    if (fsel[5] == FUNC_ALT2) begin
      pin_out_d[5] = ~i_link_active[LP0];
      pin_oe_d[5]  = 1'b1;
    end
    if (fsel[8] == FUNC_ALT2) begin
      pin_out_d[8] = ~i_link_active[LP8];
      pin_oe_d[8]  = 1'b1;
    end
    // First alternate on pin 5: hot-plug event output
    if (fsel[PIN_HOTPLUG] == FUNC_ALT1) begin
      pin_out_d[PIN_HOTPLUG] = i_hotplug_event;
      pin_oe_d[PIN_HOTPLUG]  = 1'b1;
    end
  end

  // Inputs: GPIO read-back, partition resets, expander interrupt
  always_comb begin
    gpio_in_d = pin_s;  // Pin level is readable in every mode
    for (int i = 0; i < 4; i++) begin
      preset_d[i] = (fsel[PIN_PART0 + i] == FUNC_ALT1) & ~pin_s[PIN_PART0 + i];
    end
    irq_d = (fsel[PIN_EXPIRQ] == FUNC_ALT1) & ~pin_s[PIN_EXPIRQ];
  end

  // Failover inputs: pins 4, 6, 7, and pin 6 again as the fourth
  always_comb begin
    fo_lvl = {pin_s[PIN_FAIL1], pin_s[PIN_FAIL2], pin_s[PIN_FAIL1], pin_s[PIN_FAIL0]};
    fo_sel = {fsel[PIN_FAIL1] == FUNC_ALT2,
              fsel[PIN_FAIL2] == FUNC_ALT1,
              fsel[PIN_FAIL1] == FUNC_ALT1,
              fsel[PIN_FAIL0] == FUNC_ALT1};
    fo_prev_d = fo_lvl;
    // Event on any level change while selected and enabled
    fo_ev_d = (fo_lvl ^ fo_prev_q) & fo_sel & i_failover_enable;
  end

  // Straps are caught once the synchroniser has settled after reset, then held
  always_comb begin
    strap_d      = strap_q;
    strap_done_d = strap_done_q;
    strap_cnt_d  = strap_cnt_q;
    if (!strap_done_q) begin
      if (strap_cnt_q == STRAP_CNT_W'(STRAP_SETTLE_CYCLES)) begin
        strap_d      = strap_s;
        strap_done_d = 1'b1;
      end else begin
        strap_cnt_d  = strap_cnt_q + STRAP_CNT_W'(1);
      end
    end
  end

  // Register all state
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      func_q       <= FUNC_SEL_RST;
      pin_out_q    <= '0;
      pin_oe_q     <= '0;
      gpio_in_q    <= PIN_SYNC_RST;
      preset_q     <= '0;
      irq_q        <= 1'b0;
      fo_prev_q    <= '1;
      fo_ev_q      <= '0;
      strap_q      <= '0;
      strap_done_q <= 1'b0;
      strap_cnt_q  <= '0;
    end else begin
      func_q       <= func_d;
      pin_out_q    <= pin_out_d;
      pin_oe_q     <= pin_oe_d;
      gpio_in_q    <= gpio_in_d;
      preset_q     <= preset_d;
      irq_q        <= irq_d;
      fo_prev_q    <= fo_prev_d;
      fo_ev_q      <= fo_ev_d;
      strap_q      <= strap_d;
      strap_done_q <= strap_done_d;
      strap_cnt_q  <= strap_cnt_d;
    end
  end

  // Outputs
  assign o_func_sel           = func_q;
  assign o_pin                = pin_out_q;
  assign o_pin_oe             = pin_oe_q;
  assign o_gpio_in            = gpio_in_q;
  assign o_partition_reset    = preset_q;
  assign o_failover_event     = fo_ev_q;
  assign o_expander_irq       = irq_q;
  assign o_stack_config       = strap_q[3:0];
  assign o_port_clocking_mode = strap_q[5:4];
  assign o_refclk_freq_select = strap_q[6];
  assign o_refclk_mhz         = (strap_q[6] == REFCLK_SEL_100) ?
                                8'(REFCLK_MHZ_100) : 8'(REFCLK_MHZ_125);
endmodule : gpio_alternate_function_mux
`default_nettype wire

// ---- hdl/gpio_mux_pkg.sv ----
`default_nettype none
package gpio_mux_pkg;
  // Pin count and function select encoding
  localparam int unsigned NUM_PINS       = 9;
  localparam logic [1:0]  FUNC_GPIO      = 2'h0;
  localparam logic [1:0]  FUNC_ALT1      = 2'h1;
  localparam logic [1:0]  FUNC_ALT2      = 2'h2;
  localparam logic [1:0]  FUNC_RESERVED  = 2'h3;
  // Pin indices
  localparam int unsigned PIN_PART0      = 0;
  localparam int unsigned PIN_PART1      = 1;
  localparam int unsigned PIN_PART2      = 2;
  localparam int unsigned PIN_PART3      = 3;
  localparam int unsigned PIN_FAIL0      = 4;
  localparam int unsigned PIN_HOTPLUG    = 5;
  localparam int unsigned PIN_FAIL1      = 6;
  localparam int unsigned PIN_FAIL2      = 7;
  localparam int unsigned PIN_EXPIRQ     = 8;
  // Reference clock frequency codes, in MHz
  localparam logic        REFCLK_SEL_100 = 1'b0;
  localparam int unsigned REFCLK_MHZ_100 = 100;
  localparam int unsigned REFCLK_MHZ_125 = 125;
  // Edges after reset release before the strap synchroniser output is trusted
  localparam int unsigned STRAP_SETTLE_CYCLES = 4;
  // Reset values
  localparam logic [17:0] FUNC_SEL_RST   = 18'h00000;
  localparam logic [8:0]  PIN_SYNC_RST   = 9'h1FF;
endpackage : gpio_mux_pkg
`default_nettype wire

// ---- hdl/pin_sync.sv ----
`default_nettype none
// Three-stage synchroniser; the output moves only when stages two and three agree
module pin_sync
  import gpio_mux_pkg::*;
#(
  parameter int unsigned WIDTH     = NUM_PINS,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  // Raw and filtered levels
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
  logic [WIDTH-1:0] out_d;

  // Elaboration check on the width
  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync: WIDTH must be at least 1");
  end

  // Per-bit agreement filter
  for (genvar b = 0; b < WIDTH; b++) begin : g_bit
    always_comb begin
      out_d[b] = (s2_q[b] == s3_q[b]) ? s3_q[b] : out_q[b];
    end
  end

  // Register stages
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_q  <= RST_VAL;
      s2_q  <= RST_VAL;
      s3_q  <= RST_VAL;
      out_q <= RST_VAL;
    end else begin
      s1_q  <= i_async;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign o_sync = out_q;
endmodule : pin_sync
`default_nettype wire

// ---- test/gpio_mux_asserts.sv ----
`default_nettype none
module gpio_mux_asserts
  import gpio_mux_pkg::*;
(
  // Clock and reset
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  // Select state
  input wire logic        i_func_sel_we,
  input wire logic [17:0] i_func_sel,
  input wire logic [17:0] o_func_sel,
  // Pins and functions
  input wire logic [8:0]  i_pin,
  input wire logic [8:0]  o_pin,
  input wire logic [8:0]  o_pin_oe,
  input wire logic [3:0]  o_partition_reset,
  input wire logic [3:0]  o_failover_event,
  input wire logic        i_hotplug_event,
  input wire logic        o_expander_irq,
  input wire logic [3:0]  i_link_up,
  input wire logic [3:0]  i_link_active,
  input wire logic        o_refclk_freq_select,
  input wire logic [7:0]  o_refclk_mhz
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Pin 4 level moved five and six edges back
  sequence s_pin4_edge;
    $past(i_pin[4], 5) != $past(i_pin[4], 6);
  endsequence
  a_sel_capture: assert property (i_func_sel_we |=> o_func_sel == $past(i_func_sel))
    else $error("select write not captured");
  a_up16_drive: assert property (o_func_sel[1:0] == FUNC_ALT2 |=>
    o_pin_oe[0] && o_pin[0] == !$past(i_link_up[3])) else $error("port16 link-up wrong");
  a_act8_drive: assert property (o_func_sel[17:16] == FUNC_ALT2 |=>
    o_pin_oe[8] && o_pin[8] == !$past(i_link_active[2])) else $error("port8 active wrong");
  a_hotplug_drive: assert property (o_func_sel[11:10] == FUNC_ALT1 |=>
    o_pin_oe[5] && o_pin[5] == $past(i_hotplug_event)) else $error("hot-plug pin wrong");
  a_part_reset: assert property ($rose(o_partition_reset[1]) |-> !$past(i_pin[1], 5))
    else $error("partition reset without low pin");
  a_failover_edge: assert property (o_failover_event[0] |-> s_pin4_edge)
    else $error("failover event without level change");
  a_irq_level: assert property ($rose(o_expander_irq) |-> !$past(i_pin[8], 5))
    else $error("expander irq without low pin");
  a_refclk_code: assert property (o_refclk_mhz == (o_refclk_freq_select ? 8'h7D : 8'h64))
    else $error("refclk frequency code wrong");
endmodule : gpio_mux_asserts
bind gpio_alternate_function_mux gpio_mux_asserts u_chk (.i_sys_clk, .i_rst, .i_func_sel_we,
  .i_func_sel, .o_func_sel, .i_pin, .o_pin, .o_pin_oe, .o_partition_reset, .o_failover_event,
  .i_hotplug_event, .o_expander_irq, .i_link_up, .i_link_active, .o_refclk_freq_select,
  .o_refclk_mhz);
`default_nettype wire

// ---- test/pin_board.sv ----
`default_nettype none
module pin_board (
  // Device drive
  input  wire logic [8:0] i_drv,
  input  wire logic [8:0] i_drv_oe,
  // Board drive and wire level
  input  wire logic [8:0] i_brd,
  input  wire logic [8:0] i_brd_oe,
  output logic      [8:0] o_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // Device drive first, then board, else board pull-up
  assign o_lvl = (i_drv_oe & i_drv) | (~i_drv_oe & i_brd_oe & i_brd) | ~(i_drv_oe | i_brd_oe);
endmodule : pin_board
`default_nettype wire

// ---- test/tb.sv ----
`default_nettype none
module tb
  import gpio_mux_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_sys_clk = 1'b0, i_rst = 1'b1, i_func_sel_we = 1'b0;
  logic [17:0] i_func_sel = 18'h00000, o_func_sel;
  logic [8:0]  i_gpio_out = 9'h000, i_gpio_dir_out = 9'h000, o_gpio_in, i_pin, o_pin, o_pin_oe;
  logic [8:0]  brd_val = 9'h000, brd_en = 9'h000;
  logic [3:0]  o_partition_reset, i_failover_enable = 4'hB, o_failover_event, u, a;
  logic        i_hotplug_event = 1'b0, o_expander_irq, i_refclk_freq_select = 1'b1;
  logic [3:0]  i_link_up = 4'h0, i_link_active = 4'h0, i_stack_config_strap = 4'hA;
  logic [1:0]  i_port_clocking_strap = 2'h2, o_port_clocking_mode;
  logic [3:0]  o_stack_config, evc [4] = '{default: 4'h0}, e0 [4];
  logic        o_refclk_freq_select;
  logic [7:0]  o_refclk_mhz;
  int          miscompares = 0, checks_done = 0, cycles = 0;

  gpio_alternate_function_mux DUT (.i_sys_clk, .i_rst, .i_func_sel_we, .i_func_sel, .o_func_sel,
    .i_gpio_out, .i_gpio_dir_out, .o_gpio_in, .i_pin, .o_pin, .o_pin_oe, .o_partition_reset,
    .i_failover_enable, .o_failover_event, .i_hotplug_event, .o_expander_irq, .i_link_up,
    .i_link_active, .i_stack_config_strap, .i_port_clocking_strap, .i_refclk_freq_select,
    .o_stack_config, .o_port_clocking_mode, .o_refclk_freq_select, .o_refclk_mhz);
  pin_board BRD (.i_drv(o_pin), .i_drv_oe(o_pin_oe), .i_brd(brd_val), .i_brd_oe(brd_en),
    .o_lvl(i_pin));

  // Clock
  initial forever #5 i_sys_clk = ~i_sys_clk;
  // Failover pulse counters and hang guard
  always @(posedge i_sys_clk) begin
    foreach (evc[k]) evc[k] <= evc[k] + 4'(o_failover_event[k]);
    cycles++;
    if (cycles == 1000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic chk(input string n, input logic [17:0] e, input logic [17:0] s);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Failover pulses counted since the last snapshot, one nibble per trigger
  function automatic logic [17:0] ev_delta();
    return {2'h0, evc[3] - e0[3], evc[2] - e0[2], evc[1] - e0[1], evc[0] - e0[0]};
  endfunction : ev_delta

  task automatic wt(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : wt

  task automatic set_sel(input logic [17:0] v);
    @(posedge i_sys_clk);
    i_func_sel <= v;
    i_func_sel_we <= 1'b1;
    @(posedge i_sys_clk);
    i_func_sel_we <= 1'b0;
    wt(9);
  endtask : set_sel

  task automatic print_verdict;
    if (miscompares == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  // Main sequence
  initial begin
    wt(4);
    i_rst <= 1'b0;
    wt(8);
    chk("func_sel", 18'h0, o_func_sel);
    chk("pin_oe", 18'h0, o_pin_oe);
    chk("straps", 18'h55,
      {o_stack_config, o_port_clocking_mode, o_refclk_freq_select});
    chk("refclk_mhz", 18'h7D, o_refclk_mhz);
    i_gpio_out <= 9'h080;
    i_gpio_dir_out <= 9'h180;
    brd_en <= 9'h001;
    wt(8);
    chk("gpio_drive", 18'h080, o_pin);
    chk("gpio_pins", 18'h0FE, i_pin);
    chk("gpio_in", 18'h0FE, o_gpio_in);
    i_gpio_dir_out <= 9'h000;
    brd_en <= 9'h000;
    set_sel(18'h2AAAA);
    for (int i = 0; i < 16; i += 5) begin
      u = i[3:0];
      a = ~u;
      i_link_up <= u;
      i_link_active <= a;
      wt(3);
      chk("alt2_oe", 18'h1BF, o_pin_oe);
      chk("link_pins", {9'h0, ~a[2], ~u[2], 1'b1, ~a[0], ~u[0], ~a[1], ~u[1], ~a[3], ~u[3]},
        {9'h0, i_pin});
    end
    set_sel(18'h15555);
    i_hotplug_event <= 1'b1;
    brd_en <= 9'h10A;
    wt(8);
    e0 = evc;
    chk("part_reset", 18'hA, o_partition_reset);
    chk("exp_irq", 18'h1, o_expander_irq);
    chk("hotplug_pin", 18'h1, i_pin[5]);
    i_hotplug_event <= 1'b0;
    brd_en <= 9'h0D0;
    wt(8);
    chk("part_free", 18'h0, {o_partition_reset, o_expander_irq, i_pin[5]});
    chk("fail_evt", 18'h00011, ev_delta());
    set_sel(18'h16555);
    e0 = evc;
    brd_en <= 9'h090;
    wt(8);
    chk("fail3_evt", 18'h01000, ev_delta());
    set_sel(18'h3FFFF);
    chk("resv_oe", 18'h0, o_pin_oe);
    i_refclk_freq_select <= 1'b0;
    i_rst <= 1'b1;
    wt(4);
    chk("rst_sel", 18'h0, o_func_sel);
    i_rst <= 1'b0;
    wt(8);
    chk("refclk_100", 18'h64, o_refclk_mhz);
    chk("straps_again", 18'h54,
      {o_stack_config, o_port_clocking_mode, o_refclk_freq_select});
    print_verdict();
  end
endmodule : tb
`default_nettype wire
